/* File: src/hipm_params.svh */
`ifndef HIPM_PARAMS_SVH
`define HIPM_PARAMS_SVH
// Notes on behaviour
// RQ1 - All pads high impedance during reset/power-up
// RQ2 - Pads take selected alternate function else GPIO
// RQ3 - Host pads follow SDIO, SPI or float
// RQ4 - SPI slave ignores bus while select high
// RQ5 - SPI mode drives interrupt output to host
// RQ6 - UART rx/tx pads only in UART mode
// RQ7 - RTS/CTS pads only with flow control
// RQ8 - Transfer to host only when ready permits
// RQ9 - Host-ready honoured only in UART mode
// RQ10 - Wake output asks host to wake
// RQ11 - Sleep indicator low in sleep, high awake
// RQ12 - Bypass high during boot skips host commands
// RQ13 - Bypass high after boot wakes from sleep
// RQ14 - Accept coex request and priority inputs
// RQ15 - Drive flash clock, select, four data lines
// RQ16 - Debug UART tx default on, floats in sleep
// RQ17 - Default functions only after boot completes
// RQ18 - Sleep states applied while asleep
// RQ19 - Host type captured once at boot
// ------------------------------------------------
// Constants
// ------------------------------------------------
`define HIPM_HOST_SDIO  2'h0
`define HIPM_HOST_SPI   2'h1
`define HIPM_HOST_UART  2'h2
`define HIPM_HOST_NONE  2'h3
`define HIPM_FN_GPIO    1'h0
`define HIPM_FN_ALT     1'h1
// Number of shared host pads and of software-configurable pads
`define HIPM_HOST_PADS  6
`define HIPM_CFG_PADS   12
// Configurable pad indices
`define HIPM_P_COEX_GNT 0
`define HIPM_P_HRDY     1
`define HIPM_P_WAKE     2
`define HIPM_P_RTS      3
`define HIPM_P_CTS      4
`define HIPM_P_QCLK     5
`define HIPM_P_QD0      6
`define HIPM_P_QD1      7
`define HIPM_P_QCS      8
`define HIPM_P_QD2      9
`define HIPM_P_QD3      10
`define HIPM_P_COEX_REQ 11
`endif

/* File: src/hipm_pkg.sv */
`include "hipm_params.svh"
package hipm_pkg;
    typedef logic [1:0] hipm_host_t;
    typedef struct packed {
        logic [`HIPM_HOST_PADS-1:0] o;
        logic [`HIPM_HOST_PADS-1:0] oe;
    } hipm_pads_t;
    typedef struct packed {
        logic [`HIPM_CFG_PADS-1:0] o;
        logic [`HIPM_CFG_PADS-1:0] oe;
    } hipm_cpads_t;
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_BOOT  = 3'b010,
        ST_RUN   = 3'b100
    } hipm_phase_t;
endpackage

/* File: src/hipm_pad_cell.sv */
`include "hipm_params.svh"
// One configurable pad: GPIO or alternate output, floated when gated off
module hipm_pad_cell (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic gate_on,
    input  wire logic fn_sel,
    input  wire logic gpio_o,
    input  wire logic gpio_oe,
    input  wire logic alt_o,
    input  wire logic alt_oe,
    output logic      pad_o,
    output logic      pad_oe
);
    typedef struct packed {
        logic o;
        logic oe;
    } hipm_cell_st_t;
    hipm_cell_st_t st_q;
    hipm_cell_st_t st_d;
    always_comb begin
        st_d = '{o: 1'b0, oe: 1'b0};
        if (gate_on) begin
            if (fn_sel == `HIPM_FN_ALT) begin
                st_d = '{o: alt_o, oe: alt_oe}; // RQ2
            end else begin
                st_d = '{o: gpio_o, oe: gpio_oe}; // RQ2
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= '{o: 1'b0, oe: 1'b0}; // RQ1
        end else begin
            st_q <= st_d;
        end
    end
    assign pad_o  = st_q.o;
    assign pad_oe = st_q.oe;
endmodule

/* File: src/hipm_top.sv */
`include "hipm_params.svh"
// Host-interface pad multiplexer. Host pad bit order:
// 0 clk, 1 cmd/select_n, 2 d0/mosi, 3 d1/miso, 4 d2/irq, 5 d3
module hipm_top (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    // Chip state
    input  wire logic                       boot_done,
    input  wire logic                       sleep_active,
    input  wire hipm_pkg::hipm_host_t       host_type_strap,
    input  wire logic                       uart_flow_en,
    input  wire logic [`HIPM_CFG_PADS-1:0]  pad_fn_sel,
    input  wire logic [`HIPM_CFG_PADS-1:0]  gpio_o,
    input  wire logic [`HIPM_CFG_PADS-1:0]  gpio_oe,
    // Shared host pads
    input  wire logic [`HIPM_HOST_PADS-1:0] host_pad_i,
    output hipm_pkg::hipm_pads_t            host_pad,
    // Core-side host functions
    input  wire logic                       sdio_cmd_o,
    input  wire logic                       sdio_cmd_oe,
    input  wire logic [3:0]                 sdio_dat_o,
    input  wire logic [3:0]                 sdio_dat_oe,
    output logic                            sdio_clk,
    output logic                            sdio_cmd_i,
    output logic [3:0]                      sdio_dat_i,
    input  wire logic                       spi_miso,
    input  wire logic                       spi_irq_req,
    output logic                            spi_sclk,
    output logic                            spi_mosi,
    output logic                            spi_selected,
    // Host UART and debug UART
    input  wire logic                       uart_tx_core,
    output logic                            uart_rx_core,
    input  wire logic                       host_uart_rx_pad,
    output logic                            host_uart_tx_pad_o,
    output logic                            host_uart_tx_pad_oe,
    input  wire logic                       rts_core,
    output logic                            cts_core,
    input  wire logic                       debug_uart_tx_core,
    output logic                            debug_uart_tx_pad_o,
    output logic                            debug_uart_tx_pad_oe,
    // Configurable pads
    input  wire logic [`HIPM_CFG_PADS-1:0]  cfg_pad_i,
    output hipm_pkg::hipm_cpads_t           cfg_pad,
    // Wake, sleep and transfer gating
    input  wire logic                       wake_host_req,
    input  wire logic                       tx_pending,
    output logic                            tx_start_ok,
    output logic                            sleep_indicator_out,
    input  wire logic                       boot_bypass_wake_in,
    output logic                            boot_bypass_flash,
    output logic                            sleep_wake_req,
    // Coexistence and flash
    input  wire logic                       coex_grant_core,
    output logic                            coex_request,
    output logic                            coex_priority,
    input  wire logic                       coex_priority_in,
    input  wire logic                       flash_clk_core,
    input  wire logic                       flash_select_n_core,
    input  wire logic [3:0]                 flash_dat_o,
    input  wire logic [3:0]                 flash_dat_oe,
    output logic [3:0]                      flash_dat_i
);
    import hipm_pkg::*;

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    typedef struct packed {
        hipm_phase_t ph;
        hipm_host_t  host;
        hipm_pads_t  hp;
        logic        sdio_clk;
        logic        sdio_cmd_i;
        logic [3:0]  sdio_dat_i;
        logic        spi_sclk;
        logic        spi_mosi;
        logic        spi_sel;
        logic        utx_o;
        logic        utx_oe;
        logic        urx;
        logic        cts;
        logic        dtx_o;
        logic        dtx_oe;
        logic        tx_ok;
        logic        sleep_ind;
        logic        byp;
        logic        wake;
        logic        creq;
        logic        cpri;
        logic [3:0]  fdat_i;
    } hipm_st_t;

    hipm_st_t st_q;
    hipm_st_t st_d;
    logic     run_on;
    logic     is_sdio;
    logic     is_spi;
    logic     is_uart;
    logic [`HIPM_CFG_PADS-1:0] alt_o;
    logic [`HIPM_CFG_PADS-1:0] alt_oe;
    logic [`HIPM_CFG_PADS-1:0] fn_eff;

    assign run_on  = (st_q.ph == ST_RUN) && !sleep_active; // RQ17 RQ18
    assign is_sdio = run_on && (st_q.host == `HIPM_HOST_SDIO);
    assign is_spi  = run_on && (st_q.host == `HIPM_HOST_SPI);
    assign is_uart = run_on && (st_q.host == `HIPM_HOST_UART);

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb begin
        st_d = st_q;
        unique case (st_q.ph)
            ST_RESET: begin
                st_d.host = host_type_strap; // RQ19
                st_d.ph   = ST_BOOT;
            end
            ST_BOOT: begin
                if (boot_done) begin
                    st_d.ph = ST_RUN; // RQ17
                end
            end
            ST_RUN: begin
                st_d.ph = ST_RUN;
            end
        endcase
        st_d.hp         = '{o: '0, oe: '0};
        st_d.sdio_clk   = 1'b0;
        st_d.sdio_cmd_i = 1'b1;
        st_d.sdio_dat_i = 4'hf;
        st_d.spi_sclk   = 1'b0;
        st_d.spi_mosi   = 1'b0;
        st_d.spi_sel    = 1'b0;
        if (is_sdio) begin // RQ3
            st_d.sdio_clk   = host_pad_i[0];
            st_d.sdio_cmd_i = host_pad_i[1];
            st_d.sdio_dat_i = host_pad_i[5:2];
            st_d.hp.o       = {sdio_dat_o, sdio_cmd_o, 1'b0};
            st_d.hp.oe      = {sdio_dat_oe, sdio_cmd_oe, 1'b0};
        end else if (is_spi) begin // RQ3
            st_d.spi_sel  = !host_pad_i[1]; // RQ4
            st_d.spi_sclk = host_pad_i[0];
            st_d.spi_mosi = host_pad_i[2];
            // Miso floats while deselected so other slaves can share it
            st_d.hp.o[3]  = spi_miso;
            st_d.hp.oe[3] = !host_pad_i[1]; // RQ4
            st_d.hp.o[4]  = spi_irq_req; // RQ5
            st_d.hp.oe[4] = 1'b1; // RQ5
        end
        st_d.utx_o  = is_uart ? uart_tx_core : 1'b1; // RQ6
        st_d.utx_oe = is_uart; // RQ6
        st_d.urx    = is_uart ? host_uart_rx_pad : 1'b1;
        st_d.cts    = (is_uart && uart_flow_en && pad_fn_sel[`HIPM_P_CTS])
                      ? cfg_pad_i[`HIPM_P_CTS] : 1'b0; // RQ7
        st_d.dtx_o  = run_on ? debug_uart_tx_core : 1'b1; // RQ16
        st_d.dtx_oe = run_on; // RQ16
        // Host-ready gates transfers only in UART mode
        st_d.tx_ok  = tx_pending && (!(is_uart && pad_fn_sel[`HIPM_P_HRDY])
                      || cfg_pad_i[`HIPM_P_HRDY]); // RQ8 RQ9
        st_d.sleep_ind = !sleep_active; // RQ11
        st_d.byp  = (st_q.ph != ST_RUN) && boot_bypass_wake_in; // RQ12
        st_d.wake = (st_q.ph == ST_RUN) && sleep_active && boot_bypass_wake_in; // RQ13
        st_d.creq = run_on && pad_fn_sel[`HIPM_P_COEX_REQ]
                    && cfg_pad_i[`HIPM_P_COEX_REQ]; // RQ14
        st_d.cpri = run_on && coex_priority_in; // RQ14
        st_d.fdat_i = {cfg_pad_i[`HIPM_P_QD3], cfg_pad_i[`HIPM_P_QD2],
                       cfg_pad_i[`HIPM_P_QD1], cfg_pad_i[`HIPM_P_QD0]}; // RQ15
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= '{ph: ST_RESET, host: `HIPM_HOST_NONE, hp: '{o: '0, oe: '0},
                      sdio_cmd_i: 1'b1, sdio_dat_i: 4'hf, utx_o: 1'b1, urx: 1'b1,
                      dtx_o: 1'b1, sleep_ind: 1'b1, default: '0}; // RQ1
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------
    // Configurable pads
    // ------------------------------------------------
    always_comb begin
        alt_o  = '0;
        alt_oe = '0;
        fn_eff = pad_fn_sel;
        alt_o[`HIPM_P_COEX_GNT]  = coex_grant_core; // RQ14
        alt_oe[`HIPM_P_COEX_GNT] = 1'b1;
        alt_o[`HIPM_P_WAKE]      = wake_host_req; // RQ10
        alt_oe[`HIPM_P_WAKE]     = 1'b1;
        alt_o[`HIPM_P_RTS]       = rts_core;
        alt_oe[`HIPM_P_RTS]      = 1'b1;
        fn_eff[`HIPM_P_RTS] = pad_fn_sel[`HIPM_P_RTS] && is_uart && uart_flow_en; // RQ7
        fn_eff[`HIPM_P_CTS] = pad_fn_sel[`HIPM_P_CTS] && is_uart && uart_flow_en; // RQ7
        fn_eff[`HIPM_P_HRDY] = pad_fn_sel[`HIPM_P_HRDY] && is_uart; // RQ9
        alt_o[`HIPM_P_QCLK]  = flash_clk_core; // RQ15
        alt_oe[`HIPM_P_QCLK] = 1'b1;
        alt_o[`HIPM_P_QCS]   = flash_select_n_core; // RQ15
        alt_oe[`HIPM_P_QCS]  = 1'b1;
        {alt_o[`HIPM_P_QD3], alt_o[`HIPM_P_QD2], alt_o[`HIPM_P_QD1],
         alt_o[`HIPM_P_QD0]} = flash_dat_o; // RQ15
        {alt_oe[`HIPM_P_QD3], alt_oe[`HIPM_P_QD2], alt_oe[`HIPM_P_QD1],
         alt_oe[`HIPM_P_QD0]} = flash_dat_oe; // RQ15
    end

    genvar gi;
    generate
        for (gi = 0; gi < `HIPM_CFG_PADS; gi++) begin : g_pad
            hipm_pad_cell u_cell (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .gate_on (run_on),
                .fn_sel  (fn_eff[gi]),
                .gpio_o  (gpio_o[gi]),
                .gpio_oe (gpio_oe[gi]),
                .alt_o   (alt_o[gi]),
                .alt_oe  (alt_oe[gi]),
                .pad_o   (cfg_pad.o[gi]),
                .pad_oe  (cfg_pad.oe[gi])
            ); // RQ2 RQ18
        end
    endgenerate

    // ------------------------------------------------
    // Outputs
    // ------------------------------------------------
    assign host_pad             = st_q.hp;
    assign sdio_clk             = st_q.sdio_clk;
    assign sdio_cmd_i           = st_q.sdio_cmd_i;
    assign sdio_dat_i           = st_q.sdio_dat_i;
    assign spi_sclk             = st_q.spi_sclk;
    assign spi_mosi             = st_q.spi_mosi;
    assign spi_selected         = st_q.spi_sel;
    assign host_uart_tx_pad_o   = st_q.utx_o;
    assign host_uart_tx_pad_oe  = st_q.utx_oe;
    assign uart_rx_core         = st_q.urx;
    assign cts_core             = st_q.cts;
    assign debug_uart_tx_pad_o  = st_q.dtx_o;
    assign debug_uart_tx_pad_oe = st_q.dtx_oe;
    assign tx_start_ok          = st_q.tx_ok;
    assign sleep_indicator_out  = st_q.sleep_ind;
    assign boot_bypass_flash    = st_q.byp;
    assign sleep_wake_req       = st_q.wake;
    assign coex_request         = st_q.creq;
    assign coex_priority        = st_q.cpri;
    assign flash_dat_i          = st_q.fdat_i;
endmodule

/* File: verification/hipm_top_sva.sv */
`include "hipm_params.svh"
module hipm_top_sva
    import hipm_pkg::*;
(
    input wire logic                      mclk,
    input wire logic                      rst_n,
    input wire logic                      boot_done,
    input wire logic                      sleep_active,
    input wire hipm_pkg::hipm_host_t      host_type_strap,
    input wire logic                      uart_flow_en,
    input wire logic [`HIPM_CFG_PADS-1:0] pad_fn_sel,
    input wire logic [`HIPM_CFG_PADS-1:0] gpio_oe,
    input wire logic [5:0]                host_pad_i,
    input wire hipm_pkg::hipm_pads_t      host_pad,
    input wire logic                      sdio_cmd_oe,
    input wire logic [3:0]                sdio_dat_oe,
    input wire logic                      spi_irq_req,
    input wire logic                      host_uart_tx_pad_oe,
    input wire logic                      debug_uart_tx_core,
    input wire logic                      debug_uart_tx_pad_o,
    input wire logic                      debug_uart_tx_pad_oe,
    input wire hipm_pkg::hipm_cpads_t     cfg_pad,
    input wire logic [`HIPM_CFG_PADS-1:0] cfg_pad_i,
    input wire logic                      tx_pending,
    input wire logic                      tx_start_ok,
    input wire logic                      sleep_indicator_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------------------
    // Phase tracking
    // --------------------
    logic       cap_q;
    logic       run_q;
    hipm_host_t type_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cap_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            cap_q <= 1'b1;
            run_q <= run_q | (cap_q & boot_done);
        end
    end
    always_ff @(posedge mclk) begin
        if (rst_n && !cap_q) begin
            type_q <= host_type_strap;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Three awake samples so the registered gate has settled
    sequence awake_s;
        (run_q && !sleep_active)[*3];
    endsequence
    sequence asleep_s;
        sleep_active ##1 sleep_active;
    endsequence
    // --------------------
    // Properties
    // --------------------
    reset_float_a: assert property (disable iff (1'b0) !rst_n |=>
        host_pad.oe == '0 && cfg_pad.oe == '0 && !debug_uart_tx_pad_oe) else $error("pad driven in reset");
    sleep_float_a: assert property (asleep_s |-> host_pad.oe == '0 && cfg_pad.oe == '0
        && !debug_uart_tx_pad_oe && !host_uart_tx_pad_oe) else $error("pad driven in sleep");
    sleep_ind_a: assert property ($past(rst_n) |-> sleep_indicator_out == !$past(sleep_active))
        else $error("sleep indicator wrong");
    spi_irq_a: assert property (awake_s ##0 type_q == `HIPM_HOST_SPI |-> host_pad.oe[4]
        && host_pad.o[4] == $past(spi_irq_req)) else $error("irq pad wrong");
    spi_miso_a: assert property (awake_s ##0 type_q == `HIPM_HOST_SPI |->
        host_pad.oe[3] == !$past(host_pad_i[1])) else $error("miso drive wrong");
    sdio_oe_a: assert property (awake_s ##0 type_q == `HIPM_HOST_SDIO |->
        host_pad.oe == {$past(sdio_dat_oe), $past(sdio_cmd_oe), 1'b0}) else $error("sdio oe wrong");
    uart_tx_a: assert property (awake_s |-> host_uart_tx_pad_oe == (type_q == `HIPM_HOST_UART)
        && (!type_q[1] || host_pad.oe == '0)) else $error("uart pad wrong");
    // A refused request function leaves the pad as a plain GPIO
    rts_gate_a: assert property (awake_s ##0 $past(pad_fn_sel[3]) |-> cfg_pad.oe[3] ==
        ((type_q == `HIPM_HOST_UART && $past(uart_flow_en)) || $past(gpio_oe[3])))
        else $error("rts oe wrong");
    tx_gate_a: assert property (awake_s |-> tx_start_ok == ($past(tx_pending) &&
        (type_q != `HIPM_HOST_UART || !$past(pad_fn_sel[1]) || $past(cfg_pad_i[1]))))
        else $error("tx start wrong");
    dbg_tx_a: assert property (awake_s |-> debug_uart_tx_pad_oe
        && debug_uart_tx_pad_o == $past(debug_uart_tx_core)) else $error("debug tx wrong");
endmodule
bind hipm_top hipm_top_sva u_sva (.*);

/* File: verification/hipm_host_model.sv */
`include "hipm_params.svh"
module hipm_host_model
    import hipm_pkg::*;
(
    input  wire logic                 mclk,
    input  wire hipm_pkg::hipm_host_t host_type,
    input  wire logic [5:0]           host_drv,
    input  wire hipm_pkg::hipm_pads_t host_pad,
    output logic [5:0]                host_pad_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       tog_q = 1'b0;
    logic [5:0] own;
    // Undriven lines wander so a stale value never passes
    always @(posedge mclk) tog_q <= ~tog_q;
    always_comb begin
        own = 6'h00;
        if (host_type == `HIPM_HOST_SDIO) own = 6'h3f;
        if (host_type == `HIPM_HOST_SPI) own = 6'h07;
        for (int i = 0; i < 6; i++) begin
            host_pad_i[i] = host_pad.oe[i] ? host_pad.o[i] : (own[i] ? host_drv[i] : tog_q);
        end
    end
endmodule

/* File: verification/host_interface_pin_mux_tb.sv */
`include "hipm_params.svh"
module host_interface_pin_mux_tb;
    import hipm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0;
    logic        rst_n, boot_done, sleep_active, uart_flow_en, sdio_cmd_o, sdio_cmd_oe;
    logic        spi_miso, spi_irq_req, uart_tx_core, host_uart_rx_pad, rts_core;
    logic        debug_uart_tx_core, wake_host_req, tx_pending, boot_bypass_wake_in;
    logic        coex_grant_core, coex_priority_in, flash_clk_core, flash_select_n_core;
    logic        sdio_clk, sdio_cmd_i, spi_sclk, spi_mosi, spi_selected, uart_rx_core;
    logic        host_uart_tx_pad_o, host_uart_tx_pad_oe, cts_core, debug_uart_tx_pad_o;
    logic        debug_uart_tx_pad_oe, tx_start_ok, sleep_indicator_out, boot_bypass_flash;
    logic        sleep_wake_req, coex_request, coex_priority, on, run_m, uo;
    logic [3:0]  sdio_dat_o, sdio_dat_oe, flash_dat_o, flash_dat_oe, sdio_dat_i, flash_dat_i;
    logic [11:0] pad_fn_sel, gpio_o, gpio_oe, cfg_pad_i, ao, alo, ceo, fe;
    logic [5:0]  host_pad_i, hrnd, eo, eho;
    logic [95:0] r;
    hipm_host_t  host_type_strap, mt;
    hipm_pads_t  host_pad;
    hipm_cpads_t cfg_pad;
    int          failures = 0;
    int          total_checks = 0;
    always #50 mclk = ~mclk;
    hipm_top dut (.*);
    hipm_host_model host (.mclk, .host_type(mt), .host_drv(hrnd), .host_pad, .host_pad_i);
    // --------------------
    // Checking helpers
    // --------------------
    task automatic print_verdict();
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic drive(input logic [87:0] v);
        {pad_fn_sel, gpio_o, gpio_oe, cfg_pad_i, sdio_dat_o, sdio_dat_oe, flash_dat_o, flash_dat_oe,
         host_type_strap, hrnd, sdio_cmd_o, sdio_cmd_oe, spi_miso, spi_irq_req, uart_tx_core,
         host_uart_rx_pad, rts_core, debug_uart_tx_core, wake_host_req, tx_pending,
         boot_bypass_wake_in, coex_grant_core, coex_priority_in, flash_clk_core,
         flash_select_n_core, uart_flow_en} = v;
    endtask
    // Inputs held three cycles, so only settled levels are compared
    task automatic step();
        @(negedge mclk);
        r = {$urandom, $urandom, $urandom};
        drive(r[87:0]);
        sleep_active = run_m && ($urandom % 4 == 0);
        repeat (3) @(negedge mclk);
        on = run_m && !sleep_active;
        uo = on && mt == `HIPM_HOST_UART;
        // Functions refused outside UART fall back to the pad's GPIO role
        fe = pad_fn_sel;
        fe[1] = pad_fn_sel[1] && uo;
        fe[3] = pad_fn_sel[3] && uo && uart_flow_en;
        fe[4] = pad_fn_sel[4] && uo && uart_flow_en;
        eo = 6'h00;
        eho = 6'h00;
        if (on && mt == `HIPM_HOST_SDIO) begin
            eo = {sdio_dat_oe, sdio_cmd_oe, 1'b0};
            eho = {sdio_dat_o, sdio_cmd_o, 1'b0};
        end
        if (on && mt == `HIPM_HOST_SPI) begin
            eo = {2'b01, !host_pad_i[1], 3'b000};
            eho = {1'b0, spi_irq_req, spi_miso, 3'b000};
        end
        ao = {1'b0, flash_dat_oe[3:2], 1'b1, flash_dat_oe[1:0], 6'b101101};
        alo = {1'b0, flash_dat_o[3:2], flash_select_n_core, flash_dat_o[1:0], flash_clk_core,
               1'b0, rts_core, wake_host_req, 1'b0, coex_grant_core};
        ceo = on ? (fe & ao | ~fe & gpio_oe) : 12'h000;
        chk("host_oe", 12'(eo), 12'(host_pad.oe));
        chk("host_o", 12'(eho & eo), 12'(host_pad.o & eo));
        chk("cfg_oe", ceo, cfg_pad.oe);
        chk("cfg_o", ceo & (fe & alo | ~fe & gpio_o), ceo & cfg_pad.o);
        chk("uart_tx", 12'({uo, uo ? uart_tx_core : 1'b1}),
            12'({host_uart_tx_pad_oe, host_uart_tx_pad_o}));
        chk("uart_in", 12'({uo ? host_uart_rx_pad : 1'b1, fe[4] ? cfg_pad_i[4] : 1'b0}),
            12'({uart_rx_core, cts_core}));
        chk("dbg_tx", 12'({on, on ? debug_uart_tx_core : 1'b1}),
            12'({debug_uart_tx_pad_oe, debug_uart_tx_pad_o}));
        chk("sleep_ind", 12'(!sleep_active), 12'(sleep_indicator_out));
        chk("tx_ok", 12'(tx_pending && !(uo && pad_fn_sel[1] && !cfg_pad_i[1])),
            12'(tx_start_ok));
        chk("bypass", 12'(!run_m && boot_bypass_wake_in), 12'(boot_bypass_flash));
        chk("wake_req", 12'(run_m && sleep_active && boot_bypass_wake_in),
            12'(sleep_wake_req));
        chk("flash_in", 12'({cfg_pad_i[10:9], cfg_pad_i[7:6]}), 12'(flash_dat_i));
        chk("coex_prio", 12'(on && coex_priority_in), 12'(coex_priority));
        chk("coex_req", 12'(on && pad_fn_sel[11] && cfg_pad_i[11]), 12'(coex_request));
        chk("spi_sel", 12'(on && mt == `HIPM_HOST_SPI && !host_pad_i[1]),
            12'(spi_selected));
        chk("spi_in", 12'((on && mt == `HIPM_HOST_SPI) ? {host_pad_i[0], host_pad_i[2]} : 2'b00),
            12'({spi_sclk, spi_mosi}));
        chk("sdio_in", 12'((on && mt == `HIPM_HOST_SDIO)
            ? {host_pad_i[0], host_pad_i[1], host_pad_i[5:2]} : 6'h1f),
            12'({sdio_clk, sdio_cmd_i, sdio_dat_i}));
    endtask
    // --------------------
    // Main sequence
    // --------------------
    initial begin
        drive(88'h0);
        {rst_n, boot_done, sleep_active, run_m, mt} = '0;
        void'($urandom(32'haaf2));
        for (int t = 0; t < 4; t++) begin
            mt = hipm_host_t'(t);
            {rst_n, boot_done, sleep_active, run_m} = '0;
            repeat (16) @(negedge mclk);
            chk("rst_host", 12'h000, 12'({host_pad.oe, host_uart_tx_pad_oe, debug_uart_tx_pad_oe}));
            chk("rst_cfg", 12'h000, cfg_pad.oe);
            chk("rst_ind", 12'h001, 12'(sleep_indicator_out));
            host_type_strap = mt;
            rst_n = 1'b1;
            repeat (3) step();
            boot_done = 1'b1;
            run_m = 1'b1;
            repeat (16) step();
        end
        print_verdict();
    end
    // Whole run is a few hundred cycles; this margin is far beyond it
    initial begin
        #1_000_000;
        failures++;
        print_verdict();
    end
endmodule
